// file: core/frpi_pkg.sv
// Shared constants and types of the resume, deep-sleep and identification block.
// Assumes a 50 ns system clock; the serial link clock is free-running only in frames.
package frpi_pkg;
	localparam int CLK_NS = 50;
	localparam int CNT_W  = 7;
	localparam int TMR_W  = 10;

	// Opcodes
	localparam logic [7:0] OP_RESUME   = 8'h7a;
	localparam logic [7:0] OP_SLEEP    = 8'hb9;
	localparam logic [7:0] OP_RELEASE  = 8'hab;
	localparam logic [7:0] OP_ID       = 8'h90;
	localparam logic [7:0] OP_ID_DUAL  = 8'h92;
	localparam logic [7:0] OP_QUAD_ON  = 8'h38;
	localparam logic [7:0] OP_QUAD_OFF = 8'hff;

	// Rising link edges at which a phase ends
	localparam logic [CNT_W-1:0] OPC_END_SPI  = 7'h08;
	localparam logic [CNT_W-1:0] OPC_END_QUAD = 7'h02;
	localparam logic [CNT_W-1:0] ID_END_SPI   = 7'h20;
	localparam logic [CNT_W-1:0] ID_END_DUAL  = 7'h14;
	localparam logic [CNT_W-1:0] ID_END_QUAD  = 7'h08;

	// Times in ns; counts of clk cycles derived from them
	localparam int T_RES_BUSY_NS    = 200;
	localparam int T_SLEEP_ENTRY_NS = 3000;
	localparam int T_RELEASE_NS     = 3000;
	localparam int T_ID_RELEASE_NS  = 3000;
	localparam int T_SUSP_LAT_NS    = 20000;
	localparam int RES_BUSY_CYC     = T_RES_BUSY_NS / CLK_NS;
	localparam int SLEEP_ENTRY_CYC  = (T_SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS;
	localparam int RELEASE_CYC      = (T_RELEASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ID_RELEASE_CYC   = (T_ID_RELEASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SUSP_LAT_CYC     = T_SUSP_LAT_NS / CLK_NS;

	typedef enum logic [1:0] {W_ONE, W_TWO, W_FOUR} frpi_width_e;
	typedef enum logic [1:0] {PWR_ON, PWR_ENTER, PWR_SLEEP, PWR_WAKE} frpi_pwr_e;
endpackage

// file: core/frpi_link_if.sv
// Signals between the system-clock side and the frame engine.
// Assumes the frame engine runs on the link clock.
`timescale 1ns/10ps
interface frpi_link_if;
	import frpi_pkg::*;
	logic             mode_s;
	logic             busy_s;
	logic             sleep_s;
	logic [CNT_W-1:0] cnt_n;
	logic [7:0]       op_s_n;
	logic [7:0]       op_q_n;
	modport link (input mode_s, busy_s, sleep_s, output cnt_n, op_s_n, op_q_n);
	modport core (output mode_s, busy_s, sleep_s, input cnt_n, op_s_n, op_q_n);
endinterface

// file: core/frpi_link.sv
// Frame engine: samples lines on rising link edges, drives identification on falling ones.
// Assumes its reset is held while chip select is high, so every frame starts clean.
`timescale 1ns/10ps
module frpi_link
	import frpi_pkg::*;
#(
	parameter logic [7:0] MFR_ID    = 8'h5a,
	parameter logic [7:0] DEV_ID    = 8'h3c,
	parameter logic [7:0] LEGACY_ID = 8'h3c
)(
	// Link
	input  wire logic       sck,
	input  wire logic       frame_rst_n,
	input  wire logic [3:0] io_i,
	output logic      [3:0] io_o,
	output logic      [3:0] io_oe,
	// Core side
	frpi_link_if.link       lif
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [7:0]       s1;
		logic [7:0]       s4;
		logic [7:0]       op_s;
		logic [7:0]       op_q;
		logic             go;
		frpi_width_e      wd;
		logic [15:0]      pat;
	} frpi_rx_s;
	typedef struct packed {
		logic        on;
		logic [15:0] sh;
		logic [3:0]  drv;
		logic [3:0]  oe;
	} frpi_tx_s;

	frpi_rx_s rx_ff, nxt_rx;
	frpi_tx_s tx_ff, nxt_tx;
	logic [15:0] pair;

	// Address bit 0 picks the byte order
	assign pair = io_i[0] ? {DEV_ID, MFR_ID} : {MFR_ID, DEV_ID};

	always_comb begin
		nxt_rx = rx_ff;
		nxt_rx.cnt = (rx_ff.cnt == '1) ? rx_ff.cnt : rx_ff.cnt + 7'h01;
		nxt_rx.s1 = {rx_ff.s1[6:0], io_i[0]};
		nxt_rx.s4 = {rx_ff.s4[3:0], io_i};
		// Both forms are latched; mode is not trusted this early in a frame
		if (nxt_rx.cnt == OPC_END_SPI) begin
			nxt_rx.op_s = nxt_rx.s1;
		end
		if (nxt_rx.cnt == OPC_END_QUAD) begin
			nxt_rx.op_q = nxt_rx.s4;
		end
		if (!rx_ff.go && !lif.busy_s) begin
			if (!lif.mode_s && !lif.sleep_s && rx_ff.op_s == OP_ID && nxt_rx.cnt == ID_END_SPI) begin
				nxt_rx.go = 1'b1;
				nxt_rx.wd = W_ONE;
				nxt_rx.pat = pair;
			end else if (!lif.mode_s && !lif.sleep_s && rx_ff.op_s == OP_ID_DUAL &&
					nxt_rx.cnt == ID_END_DUAL) begin
				nxt_rx.go = 1'b1;
				nxt_rx.wd = W_TWO;
				nxt_rx.pat = pair;
			end else if (lif.mode_s && !lif.sleep_s && rx_ff.op_q == OP_ID && nxt_rx.cnt == ID_END_QUAD) begin
				nxt_rx.go = 1'b1;
				nxt_rx.wd = W_FOUR;
				nxt_rx.pat = pair;
			end else if (!lif.mode_s && rx_ff.op_s == OP_RELEASE && nxt_rx.cnt == ID_END_SPI) begin
				nxt_rx.go = 1'b1;
				nxt_rx.wd = W_ONE;
				nxt_rx.pat = {LEGACY_ID, LEGACY_ID};
			end
		end
	end

	always_comb begin
		nxt_tx = tx_ff;
		if (rx_ff.go && !tx_ff.on) begin
			nxt_tx.on = 1'b1;
			nxt_tx.sh = rx_ff.pat;
		end else if (tx_ff.on) begin
			case (rx_ff.wd)
				W_ONE:   nxt_tx.sh = {tx_ff.sh[14:0], tx_ff.sh[15]};
				W_TWO:   nxt_tx.sh = {tx_ff.sh[13:0], tx_ff.sh[15:14]};
				default: nxt_tx.sh = {tx_ff.sh[11:0], tx_ff.sh[15:12]};
			endcase
		end
		// MSB first, bytes repeat until the frame ends
		case (rx_ff.wd)
			W_ONE: begin
				nxt_tx.drv = {2'b00, nxt_tx.sh[15], 1'b0};
				nxt_tx.oe = {2'b00, nxt_tx.on, 1'b0};
			end
			W_TWO: begin
				nxt_tx.drv = {2'b00, nxt_tx.sh[15:14]};
				nxt_tx.oe = {2'b00, nxt_tx.on, nxt_tx.on};
			end
			default: begin
				nxt_tx.drv = nxt_tx.sh[15:12];
				nxt_tx.oe = {4{nxt_tx.on}};
			end
		endcase
	end

	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rx_ff <= '0;
		end else begin
			rx_ff <= nxt_rx;
		end
	end

	// Falling edges launch output data
	always_ff @(negedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_ff <= '0;
		end else begin
			tx_ff <= nxt_tx;
		end
	end

	assign lif.cnt_n = nxt_rx.cnt;
	assign lif.op_s_n = nxt_rx.op_s;
	assign lif.op_q_n = nxt_rx.op_q;
	assign io_o = tx_ff.drv;
	assign io_oe = tx_ff.oe;
endmodule

// file: core/frpi_top.sv
// Resume, deep-sleep entry and release, and identification reads of a serial flash.
// Assumes the program/erase engine reports start and end, and a separate decoder
// delivers accepted suspend requests on clk.
//
// Notes on behaviour
// - Resume is taken only with suspend flag set and busy clear.
// - Taken resume clears suspend at once, sets busy within 200 ns, engine continues.
// - Resume with suspend clear or busy set changes nothing.
// - Resume is refused when the suspended operation was lost to power failure.
// - Sleep entry runs only if chip select rises right after opcode bit eight.
// - Deep sleep begins only after the entry delay from chip select rising.
// - In deep sleep only the release opcode is recognised.
// - Power-on always starts awake, never in deep sleep.
// - Release framed alone; host keeps chip select high for release recovery.
// - Legacy identification byte only in single-line mode; four-line just releases.
// - Legacy read: opcode, three dummies, byte repeats MSB first on falling edges.
// - Release opcode is ignored while busy; the running cycle is untouched.
// - Single-line read: 8 opcode clocks, 24 address clocks, two bytes out.
// - Address zero gives manufacturer first, address one device first; bytes alternate.
// - Four-line read: opcode 2 clocks, address 6, bytes on all four lines.
// - Dual read: address on two lines in 12 clocks, bytes out on both.
// - Taken suspend sets suspend flag at once, clears busy within suspend latency.
// - Opcode takes eight clocks on one line, or two on four lines.
// - Four-line enable is ignored while the quad enable bit is clear.
`timescale 1ns/10ps
module frpi_top
	import frpi_pkg::*;
#(
	parameter int         DP_CYC    = SLEEP_ENTRY_CYC,
	parameter int         RES1_CYC  = RELEASE_CYC,
	parameter int         RES2_CYC  = ID_RELEASE_CYC,
	parameter int         SUS_CYC   = SUSP_LAT_CYC,
	parameter logic [7:0] MFR_ID    = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEV_ID    = 8'h3c, // Arbitrary value
	parameter logic [7:0] LEGACY_ID = 8'h3c  // Arbitrary value
)(
	// System
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Serial link
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic [3:0] io_i,
	output logic      [3:0] io_o,
	output logic      [3:0] io_oe,
	// Configuration
	input  wire logic       quad_enable_bit,
	// Program/erase engine
	input  wire logic       eng_start,
	input  wire logic       eng_done,
	input  wire logic       susp_req,
	input  wire logic       susp_lost,
	output logic            eng_pause,
	output logic            eng_resume,
	// Status
	output logic            suspend_flag,
	output logic            busy_flag,
	output logic            deep_sleep_state,
	output logic            four_line_command_mode
);
	if (DP_CYC < 1 || DP_CYC >= (1 << TMR_W) || RES1_CYC < 1 || RES1_CYC >= (1 << TMR_W) ||
			RES2_CYC < 1 || RES2_CYC >= (1 << TMR_W) || SUS_CYC < 1 || SUS_CYC >= (1 << TMR_W)) begin : g_bad
		$error("frpi_top: timer count out of range");
	end

	typedef struct packed {
		logic             m1;
		logic             m2;
		logic             b1;
		logic             b2;
		logic             z1;
		logic             z2;
		logic [CNT_W-1:0] hcnt;
		logic [7:0]       hop_s;
		logic [7:0]       hop_q;
	} frpi_lnk_s;

	typedef struct packed {
		logic             c1;
		logic             c2;
		logic             c3;
		frpi_pwr_e        pwr;
		logic [TMR_W-1:0] tmr;
		logic [TMR_W-1:0] stmr;
		logic             susp;
		logic             busy;
		logic             quad;
		logic             res_p;
	} frpi_core_s;

	frpi_lnk_s  lnk_ff, nxt_lnk;
	frpi_core_s core_ff, nxt_core;

	frpi_link_if lif ();

	logic       frame_rst_n;
	logic       frame;
	logic       exact;
	logic       asleep;
	logic [7:0] code;
	logic       acc_res;
	logic       acc_sus;

	// Frame engine is cleared whenever chip select is high
	assign frame_rst_n = arst_n & ~cs_n;

	frpi_link #(
		.MFR_ID    (MFR_ID),
		.DEV_ID    (DEV_ID),
		.LEGACY_ID (LEGACY_ID)
	) u_link (
		.sck         (sck),
		.frame_rst_n (frame_rst_n),
		.io_i        (io_i),
		.io_o        (io_o),
		.io_oe       (io_oe),
		.lif         (lif.link)
	);

	// Link side: state crosses in through two flops. Frame counts and opcodes
	// are held here past the frame so the clk side can read them once chip
	// select has settled high and the link clock has stopped.
	always_comb begin
		nxt_lnk = lnk_ff;
		nxt_lnk.m1 = core_ff.quad;
		nxt_lnk.m2 = lnk_ff.m1;
		nxt_lnk.b1 = core_ff.busy;
		nxt_lnk.b2 = lnk_ff.b1;
		nxt_lnk.z1 = deep_sleep_state;
		nxt_lnk.z2 = lnk_ff.z1;
		nxt_lnk.hcnt = lif.cnt_n;
		nxt_lnk.hop_s = lif.op_s_n;
		nxt_lnk.hop_q = lif.op_q_n;
	end

	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			lnk_ff <= '0;
		end else begin
			lnk_ff <= nxt_lnk;
		end
	end

	assign lif.mode_s = lnk_ff.m2;
	assign lif.busy_s = lnk_ff.b2;
	assign lif.sleep_s = lnk_ff.z2;

	// Frame end as seen on clk
	assign frame = core_ff.c2 && !core_ff.c3;
	assign code = core_ff.quad ? lnk_ff.hop_q : lnk_ff.hop_s;
	assign exact = lnk_ff.hcnt == (core_ff.quad ? OPC_END_QUAD : OPC_END_SPI);
	assign asleep = core_ff.pwr == PWR_SLEEP || core_ff.pwr == PWR_WAKE;

	assign acc_sus = susp_req && !core_ff.susp && core_ff.busy;
	// No second resume while suspend latency still runs
	assign acc_res = frame && exact && core_ff.pwr == PWR_ON && code == OP_RESUME &&
		core_ff.susp && !core_ff.busy && !susp_lost && core_ff.stmr == '0;

	always_comb begin
		nxt_core = core_ff;
		nxt_core.c1 = cs_n;
		nxt_core.c2 = core_ff.c1;
		nxt_core.c3 = core_ff.c2;
		nxt_core.res_p = 1'b0;

		// Engine start wins over a same-cycle end
		if (eng_done) begin
			nxt_core.busy = 1'b0;
		end
		if (eng_start) begin
			nxt_core.busy = 1'b1;
		end

		if (core_ff.stmr != '0) begin
			nxt_core.stmr = core_ff.stmr - 10'h001;
			if (core_ff.stmr == 10'h001) begin
				nxt_core.busy = eng_start;
			end
		end
		if (acc_sus) begin
			nxt_core.susp = 1'b1;
			nxt_core.stmr = TMR_W'(SUS_CYC);
		end

		if (acc_res) begin
			nxt_core.susp = 1'b0;
			nxt_core.busy = 1'b1;
			nxt_core.res_p = 1'b1;
		end

		case (core_ff.pwr)
			PWR_ON: begin
				if (frame && exact && code == OP_SLEEP) begin
					nxt_core.pwr = PWR_ENTER;
					nxt_core.tmr = TMR_W'(DP_CYC);
				end
				if (frame && exact && code == OP_QUAD_ON && !core_ff.quad && quad_enable_bit) begin
					nxt_core.quad = 1'b1;
				end
				if (frame && exact && code == OP_QUAD_OFF && core_ff.quad) begin
					nxt_core.quad = 1'b0;
				end
			end
			PWR_ENTER: begin
				nxt_core.tmr = core_ff.tmr - 10'h001;
				if (core_ff.tmr == 10'h001) begin
					nxt_core.pwr = PWR_SLEEP;
				end
			end
			PWR_SLEEP: begin
				// Only the release opcode is decoded here
				if (frame && code == OP_RELEASE && !core_ff.busy) begin
					if (exact) begin
						nxt_core.pwr = PWR_WAKE;
						nxt_core.tmr = TMR_W'(RES1_CYC);
					end else if (!core_ff.quad && lnk_ff.hcnt >= ID_END_SPI) begin
						nxt_core.pwr = PWR_WAKE;
						nxt_core.tmr = TMR_W'(RES2_CYC);
					end
				end
			end
			PWR_WAKE: begin
				// Frames during recovery are ignored
				nxt_core.tmr = core_ff.tmr - 10'h001;
				if (core_ff.tmr == 10'h001) begin
					nxt_core.pwr = PWR_ON;
				end
			end
			default: begin
				nxt_core.pwr = PWR_ON;
			end
		endcase
	end

	// Power-on reset always lands awake
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_ff <= '{c1: 1'b1, c2: 1'b1, c3: 1'b1, pwr: PWR_ON, default: '0};
		end else begin
			core_ff <= nxt_core;
		end
	end

	assign suspend_flag = core_ff.susp;
	assign busy_flag = core_ff.busy;
	assign deep_sleep_state = asleep;
	assign four_line_command_mode = core_ff.quad;
	assign eng_pause = core_ff.susp;
	assign eng_resume = core_ff.res_p;

	AST_RES_ACCEPT: assert property (@(posedge clk) disable iff (!arst_n)
		acc_res |=> !suspend_flag && busy_flag && eng_resume)
		else $error("resume not carried out");

	AST_RES_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && exact && code == OP_RESUME && core_ff.pwr == PWR_ON && suspend_flag && !busy_flag &&
			!susp_lost && core_ff.stmr == '0) |-> ##[1:4] busy_flag)
		else $error("busy late after resume");

	AST_RES_IGNORE: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && exact && code == OP_RESUME && (!suspend_flag || busy_flag))
			|=> !eng_resume && suspend_flag == $past(suspend_flag))
		else $error("resume taken in wrong state");

	AST_RES_LOST: assert property (@(posedge clk) disable iff (!arst_n)
		eng_resume |-> !$past(susp_lost) && $past(suspend_flag))
		else $error("resume after lost suspend");

	AST_DP_EXACT: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && core_ff.pwr == PWR_ON && code == OP_SLEEP && !exact) |=> core_ff.pwr == PWR_ON)
		else $error("sleep entered from cut frame");

	AST_DP_DELAY: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(deep_sleep_state) |-> $past(core_ff.pwr) == PWR_ENTER && $past(core_ff.tmr) == 10'h001)
		else $error("sleep entered early");

	AST_SLEEP_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && core_ff.pwr == PWR_SLEEP && code != OP_RELEASE)
			|=> core_ff.pwr == PWR_SLEEP && $stable(four_line_command_mode) && !eng_resume)
		else $error("opcode acted on in sleep");

	AST_WAKE_REC: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(deep_sleep_state) |-> $past(core_ff.pwr) == PWR_WAKE && $past(core_ff.tmr) == 10'h001)
		else $error("wake without recovery");

	AST_REL_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && core_ff.pwr == PWR_SLEEP && busy_flag) |=> core_ff.pwr == PWR_SLEEP)
		else $error("release acted on while busy");

	AST_SUS_LAT: assert property (@(posedge clk) disable iff (!arst_n)
		acc_sus |=> suspend_flag && core_ff.stmr == TMR_W'(SUS_CYC))
		else $error("suspend not taken");

	AST_SUS_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
		(core_ff.stmr == 10'h001 && !eng_start && !acc_sus) |=> !busy_flag)
		else $error("busy held past suspend latency");

	AST_QUAD_QE: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && exact && code == OP_QUAD_ON && !quad_enable_bit) |=> $stable(four_line_command_mode))
		else $error("four-line mode without quad enable");

	AST_DP_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && exact && code == OP_SLEEP && core_ff.pwr == PWR_ON)
			|=> core_ff.pwr == PWR_ENTER && core_ff.tmr == TMR_W'(DP_CYC))
		else $error("sleep entry delay not loaded");

	AST_DP_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		(core_ff.pwr == PWR_ENTER && core_ff.tmr != 10'h001) |=> !deep_sleep_state)
		else $error("sleep entered before delay ran out");

	AST_REL_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && exact && code == OP_RELEASE && core_ff.pwr == PWR_SLEEP && !busy_flag)
			|=> core_ff.pwr == PWR_WAKE && core_ff.tmr == TMR_W'(RES1_CYC))
		else $error("release recovery not loaded");

	AST_LEG_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && !exact && code == OP_RELEASE && core_ff.pwr == PWR_SLEEP && !busy_flag &&
			!four_line_command_mode && lnk_ff.hcnt >= ID_END_SPI)
			|=> core_ff.pwr == PWR_WAKE && core_ff.tmr == TMR_W'(RES2_CYC))
		else $error("identification release recovery not loaded");

	AST_WAKE_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		(core_ff.pwr == PWR_WAKE && core_ff.tmr != 10'h001) |=> deep_sleep_state)
		else $error("recovery cut short");

	AST_SLEEP_KEEP: assert property (@(posedge clk) disable iff (!arst_n)
		(core_ff.pwr == PWR_SLEEP && !frame) |=> core_ff.pwr == PWR_SLEEP)
		else $error("sleep left without a frame");

	AST_QUAD_EXACT: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && !exact) |=> $stable(four_line_command_mode))
		else $error("mode changed by a frame of wrong length");

	AST_CUT_FRAME: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && !exact && core_ff.pwr == PWR_ON) |=> !eng_resume && core_ff.pwr == PWR_ON)
		else $error("cut frame acted on");

	AST_RES_FLAGS: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(suspend_flag) |-> busy_flag && eng_resume)
		else $error("suspend cleared without busy");

	AST_SUS_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(suspend_flag) |-> $past(busy_flag) && $past(susp_req))
		else $error("suspend set while idle");

	AST_QUAD_SPI: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(four_line_command_mode) |-> $past(quad_enable_bit))
		else $error("four-line mode entered with quad enable clear");

	AST_REL_AWAKE: assert property (@(posedge clk) disable iff (!arst_n)
		(frame && code == OP_RELEASE && core_ff.pwr == PWR_ON) |=> core_ff.pwr == PWR_ON)
		else $error("release changed power state while awake");
endmodule

// file: tb/frpi_host.sv
// Host model of the serial link: frames commands on sck, cs_n and four lines.
// Assumes the device drives io_o and io_oe on falling sck and reads on rising sck.
`timescale 1ns/10ps
module frpi_host (
	// Link
	output logic            sck,
	output logic            cs_n,
	output logic      [3:0] io_i,
	input  wire logic [3:0] io_o,
	input  wire logic [3:0] io_oe
);
	logic [3:0] drv;
	logic [3:0] oe_seen;

	// Wire level: device value wins where it drives
	assign io_i = (io_oe & io_o) | (~io_oe & drv);

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		drv = 4'h5;
		oe_seen = 4'h0;
	end

	// Opcode on ow lines, na address or dummy bits on aw lines, then nrd bits read on aw lines
	task automatic frame(input logic [7:0] op, input int ow, input logic [23:0] a, input int na,
		input int aw, input int nrd, output logic [31:0] rd);
		logic [31:0] sh;
		rd = '0;
		oe_seen = 4'h0;
		cs_n = 1'b0;
		#20;
		sh = {op, 24'h0};
		for (int i = 0; i < 8; i += ow) begin
			drv = sh[31:28] >> (4 - ow);
			sh = sh << ow;
			#7.5 sck = 1'b1;
			#7.5 sck = 1'b0;
		end
		sh = {a, 8'h0};
		for (int i = 0; i < na; i += aw) begin
			drv = sh[31:28] >> (4 - aw);
			sh = sh << aw;
			#7.5 sck = 1'b1;
			#7.5 sck = 1'b0;
		end
		for (int i = 0; i < nrd; i += aw) begin
			// Released lines toggle so a stale value never reads as data
			drv = ~drv;
			#7.5 sck = 1'b1;
			// Wire level, so a line the device fails to drive reads as the toggled host value
			oe_seen = oe_seen | io_oe;
			rd = (rd << aw) | 32'((aw == 1) ? {3'h0, io_i[1]} : (aw == 2) ? {2'h0, io_i[1:0]} : io_i);
			#7.5 sck = 1'b0;
		end
		#10 cs_n = 1'b1;
		drv = ~drv;
		#20;
	endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench of the resume, deep-sleep and identification block.
// Assumes the host model frames commands; engine pulses come from here on clk.
`timescale 1ns/10ps
module testbench;
	import frpi_pkg::*;
	localparam logic [7:0] T_MFR  = 8'hc3; // Arbitrary value
	localparam logic [7:0] T_DEV  = 8'h96; // Arbitrary value
	localparam logic [7:0] T_LEG  = 8'h69; // Arbitrary value
	localparam int         T_DP   = 4;
	localparam int         T_RES1 = 4;
	localparam int         T_RES2 = 5;
	localparam int         T_SUS  = 6;

	logic        clk, arst_n, sck, cs_n, quad_enable_bit;
	logic        eng_start, eng_done, susp_req, susp_lost;
	logic [3:0]  io_i, io_o, io_oe;
	logic        eng_pause, eng_resume, suspend_flag, busy_flag, deep_sleep_state, four_line_command_mode;
	int          miscompares, total_checks, resumes;
	logic [31:0] rd;
	logic [23:0] adr;

	frpi_top #(.DP_CYC(T_DP), .RES1_CYC(T_RES1), .RES2_CYC(T_RES2), .SUS_CYC(T_SUS),
		.MFR_ID(T_MFR), .DEV_ID(T_DEV), .LEGACY_ID(T_LEG)) dut (
		.clk(clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe),
		.quad_enable_bit(quad_enable_bit), .eng_start(eng_start), .eng_done(eng_done),
		.susp_req(susp_req), .susp_lost(susp_lost), .eng_pause(eng_pause), .eng_resume(eng_resume),
		.suspend_flag(suspend_flag), .busy_flag(busy_flag), .deep_sleep_state(deep_sleep_state),
		.four_line_command_mode(four_line_command_mode));
	frpi_host host (.sck(sck), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Counted mid-cycle, where the one-cycle pulse has settled
	always @(negedge clk) begin
		if (eng_resume === 1'b1)
			resumes++;
	end
	always @(negedge clk) begin
		if (arst_n)
			chk("pause", {31'h0, suspend_flag}, {31'h0, eng_pause});
	end

	function automatic logic [31:0] st();
		return {28'h0, suspend_flag, busy_flag, deep_sleep_state, four_line_command_mode};
	endfunction
	function automatic logic [31:0] id_pat(input logic dev_first);
		return dev_first ? {T_DEV, T_MFR, T_DEV, T_MFR} : {T_MFR, T_DEV, T_MFR, T_DEV};
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic eng(input logic [2:0] v);
		@(posedge clk) {eng_start, eng_done, susp_req} <= v;
		@(posedge clk) {eng_start, eng_done, susp_req} <= 3'h0;
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#2_000_000;
		miscompares++;
		report_and_stop();
	end

	initial begin
		void'($urandom(95));
		arst_n = 1'b0;
		quad_enable_bit = 1'b0;
		{eng_start, eng_done, susp_req, susp_lost} = 4'h0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		wt(8);
		chk("reset", 32'h0, st());
		eng(3'b100);
		wt(8);
		host.frame(OP_RESUME, 1, 24'h0, 0, 1, 0, rd);
		wt(8);
		chk("resume busy", 32'h4, st());
		host.frame(OP_RELEASE, 1, 24'h0, 24, 1, 8, rd);
		chk("release busy oe", 32'h0, {28'h0, host.oe_seen});
		wt(8);
		chk("release busy", 32'h4, st());
		eng(3'b001);
		wt(1);
		chk("suspend", 32'hc, st());
		wt(T_SUS + 2);
		chk("suspend idle", 32'h8, st());
		@(posedge clk) susp_lost <= 1'b1;
		host.frame(OP_RESUME, 1, 24'h0, 0, 1, 0, rd);
		wt(8);
		chk("resume lost", 32'h8, st());
		chk("resume lost pulses", 32'h0, 32'(resumes));
		@(posedge clk) susp_lost <= 1'b0;
		host.frame(OP_RESUME, 1, 24'h0, 0, 1, 0, rd);
		wt(8);
		chk("resume", 32'h4, st());
		chk("resume pulses", 32'h1, 32'(resumes));
		wt(T_SUS);
		eng(3'b001);
		wt(T_SUS + 2);
		chk("suspend again", 32'h8, st());
		host.frame(OP_RESUME, 1, 24'h0, 0, 1, 0, rd);
		wt(8);
		chk("resume again", 32'h4, st());
		chk("resume again pulses", 32'h2, 32'(resumes));
		eng(3'b010);
		wt(8);
		chk("done", 32'h0, st());
		// Corner addresses zero and one first, then random ones
		for (int k = 0; k < 4; k++) begin
			adr = (k < 2) ? 24'(k) : 24'($urandom);
			host.frame(k[0] ? OP_ID_DUAL : OP_ID, 1, adr, 24, k[0] ? 2 : 1, 32, rd);
			chk("id", id_pat(adr[0]), rd);
			chk("id oe", k[0] ? 32'h3 : 32'h2, {28'h0, host.oe_seen});
			wt(8);
		end
		host.frame(OP_QUAD_ON, 1, 24'h0, 0, 1, 0, rd);
		wt(8);
		chk("quad refused", 32'h0, st());
		@(posedge clk) quad_enable_bit <= 1'b1;
		host.frame(OP_QUAD_ON, 1, 24'h0, 0, 1, 0, rd);
		wt(8);
		chk("quad on", 32'h1, st());
		for (int k = 0; k < 2; k++) begin
			adr = {$urandom} % 2;
			host.frame(OP_ID, 4, adr, 24, 4, 32, rd);
			chk("id quad", id_pat(adr[0]), rd);
			chk("id quad oe", 32'hf, {28'h0, host.oe_seen});
			wt(8);
		end
		host.frame(OP_RELEASE, 4, 24'h0, 24, 4, 8, rd);
		chk("legacy quad oe", 32'h0, {28'h0, host.oe_seen});
		wt(8);
		host.frame(OP_SLEEP, 4, 24'h0, 0, 4, 0, rd);
		wt(T_DP + 8);
		chk("sleep quad", 32'h3, st());
		host.frame(OP_RELEASE, 4, 24'h0, 0, 4, 0, rd);
		wt(T_RES1 + 8);
		chk("release quad", 32'h1, st());
		host.frame(OP_QUAD_OFF, 4, 24'h0, 0, 4, 0, rd);
		wt(8);
		chk("quad off", 32'h0, st());
		host.frame(OP_SLEEP, 1, 24'h0, 4, 1, 0, rd);
		wt(T_DP + 8);
		chk("sleep long", 32'h0, st());
		host.frame(OP_SLEEP, 1, 24'h0, 0, 1, 0, rd);
		wt(2);
		chk("sleep early", 32'h0, st());
		wt(T_DP + 8);
		chk("sleep", 32'h2, st());
		eng(3'b100);
		host.frame(OP_RELEASE, 1, 24'h0, 0, 1, 0, rd);
		wt(8);
		chk("release asleep busy", 32'h6, st());
		eng(3'b010);
		wt(8);
		host.frame(OP_ID, 1, 24'h0, 24, 1, 8, rd);
		chk("id asleep oe", 32'h0, {28'h0, host.oe_seen});
		wt(8);
		host.frame(OP_RELEASE, 1, 24'h0, 24, 1, 16, rd);
		chk("legacy", {16'h0, T_LEG, T_LEG}, rd);
		chk("legacy oe", 32'h2, {28'h0, host.oe_seen});
		wt(2);
		chk("recovery", 32'h2, st());
		wt(T_RES2 + 8);
		chk("awake", 32'h0, st());
		host.frame(OP_SLEEP, 1, 24'h0, 0, 1, 0, rd);
		wt(T_DP + 8);
		chk("sleep again", 32'h2, st());
		@(posedge clk) arst_n <= 1'b0;
		wt(2);
		@(posedge clk) arst_n <= 1'b1;
		wt(8);
		chk("reset asleep", 32'h0, st());
		report_and_stop();
	end
endmodule
